/* dse_pkg.sv */
package dse_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_REF     = 8'h04;
	localparam logic [7:0] OFF_FIRST_SOURCE_OPERAND    = 8'h08;
	localparam logic [7:0] OFF_FIRST_SOURCE_OPERAND_TW = 8'h0C;
	localparam logic [7:0] OFF_SECOND_SOURCE_OPERAND    = 8'h10;
	localparam logic [7:0] OFF_SECOND_SOURCE_OPERAND_TW = 8'h14;
	localparam logic [7:0] OFF_QREG    = 8'h18;
	localparam logic [7:0] OFF_STAT    = 8'h1C;
	localparam logic [7:0] OFF_DEST    = 8'h20;
	localparam logic [7:0] OFF_OPREF   = 8'h24;
	localparam logic [7:0] OFF_TRAP    = 8'h28;
	localparam logic [7:0] OFF_CAPA_HI = 8'h2C;
	localparam logic [7:0] OFF_CAPA_LO = 8'h30;
	localparam logic [7:0] OFF_CAPB_HI = 8'h34;
	localparam logic [7:0] OFF_CAPB_LO = 8'h38;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_M_BIT   = 4;
	localparam int CMD_USR_BIT = 5;
	localparam int CMD_IMM_LSB = 8;
	localparam int CMD_RA_LSB  = 16;
	localparam int CMD_RB_LSB  = 24;
	localparam int REF_RC_LSB  = 0;
	localparam int REF_VN_LSB  = 8;
	localparam int ST_DF       = 0;
	localparam int ST_N        = 1;
	localparam int ST_V        = 2;
	localparam int ST_Z        = 3;
	localparam int ST_C        = 4;
	localparam int ST_FRM_LSB  = 8;
	localparam int FRM_W       = 2;
	localparam int TR_VALID    = 0;
	localparam int TR_PROT     = 1;
	localparam int TR_VEC_LSB  = 8;

	// ****************************************
	// operation codes and limits
	// ****************************************
	localparam logic [3:0] OP_QUOT_INIT = 4'h0;
	localparam logic [3:0] OP_QUOT_STEP = 4'h1;
	localparam logic [3:0] OP_QUOT_LAST = 4'h2;
	localparam logic [3:0] OP_REM_FIX   = 4'h3;
	localparam logic [3:0] OP_DBL_GE    = 4'h4;
	localparam logic [3:0] OP_DBL_GT    = 4'h5;
	localparam logic [3:0] OP_SLONG_Q   = 4'h6;
	localparam logic [3:0] OP_ULONG_Q   = 4'h7;
	localparam logic [3:0] OP_DBL_MUL   = 4'h8;
	localparam logic [3:0] OP_DBL_SUB   = 4'h9;
	localparam logic [3:0] OP_SW_TRAP   = 4'hA;
	localparam logic [7:0] USER_VEC_MAX = 8'h3F;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;

endpackage

/* dse_alu_if.sv */
`timescale 1ns/1ps
interface dse_alu_if;
	logic [31:0] a;
	logic [31:0] b;
	logic        sub;
	logic [31:0] sum;
	logic        carry;
	logic        ovf;
	modport user (output a, b, sub, input sum, carry, ovf);
	modport unit (input a, b, sub, output sum, carry, ovf);
endinterface

/* dse_addsub.sv */
`timescale 1ns/1ps
module dse_addsub (
	dse_alu_if.unit alu
);
	logic [32:0] wide;
	logic [31:0] bx;

	// subtract is a plus inverted b plus one, so carry means no borrow
	always_comb begin
		bx        = alu.sub ? ~alu.b : alu.b;
		wide      = {1'b0, alu.a} + {1'b0, bx} + {32'h0000_0000, alu.sub};
		alu.sum   = wide[31:0];
		alu.carry = wide[32];
		alu.ovf   = (alu.a[31] == bx[31]) && (wide[31] != alu.a[31]);
	end
endmodule

/* dse_core.sv */
`timescale 1ns/1ps
module dse_core #(
	parameter logic [7:0] VEC_DBL_GE  = 8'h01,
	parameter logic [7:0] VEC_DBL_GT  = 8'h02,
	parameter logic [7:0] VEC_SLONG_Q = 8'h03,
	parameter logic [7:0] VEC_ULONG_Q = 8'h04,
	parameter logic [7:0] VEC_DBL_MUL = 8'h05,
	parameter logic [7:0] VEC_DBL_SUB = 8'h06,
	parameter logic [7:0] VEC_PROT    = 8'h07
) (
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	input  wire  logic [7:0]  paddr,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [31:0] pwdata,
	output logic       [31:0] prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              trap_pulse,
	output logic       [7:0]  trap_vector
);

	// ****************************************
	// state and registers
	// ****************************************
	typedef enum logic {DSE_IDLE, DSE_EXEC} dse_state_t;

	dse_state_t  state_q, state_d;
	logic [31:0] cmd_q, cmd_d;
	logic [31:0] ref_q, ref_d;
	logic [31:0] first_source_operand_q, first_source_operand_d;
	logic [31:0] first_source_operand_tw_q, first_source_operand_tw_d;
	logic [31:0] second_source_operand_q, second_source_operand_d;
	logic [31:0] second_source_operand_tw_q, second_source_operand_tw_d;
	logic [31:0] q_q, q_d;
	logic [31:0] dest_q, dest_d;
	logic        df_q, df_d;
	logic        n_q, n_d;
	logic        v_q, v_d;
	logic        z_q, z_d;
	logic        c_q, c_d;
	logic [dse_pkg::FRM_W-1:0] frm_q, frm_d;
	logic [7:0]  ipa_q, ipa_d;
	logic [7:0]  ipb_q, ipb_d;
	logic [7:0]  ipc_q, ipc_d;
	logic        trap_q, trap_d;
	logic        prot_q, prot_d;
	logic [7:0]  tvec_q, tvec_d;
	logic        pulse_q, pulse_d;
	logic [63:0] cap_a_q, cap_a_d;
	logic [63:0] cap_b_q, cap_b_d;
	logic [31:0] prdata_q, prdata_d;

	localparam int FRM_W = dse_pkg::FRM_W;

	// ****************************************
	// bus decode
	// ****************************************
	logic        acc;
	logic        wr;
	logic        mapped;
	logic        rd_setup;
	logic [3:0]  opc;
	logic [7:0]  ra_num;
	logic [7:0]  rb_num;
	logic [7:0]  rc_num;
	logic [7:0]  vnum;
	logic [31:0] src_b;
	logic [63:0] dbl_a;
	logic [63:0] dbl_b;
	logic        new_df;
	logic [31:0] rem_val;

	dse_alu_if alu ();

	dse_addsub u_addsub (
		.alu (alu.unit)
	);

	// zero wait states; an error marks any address past the last register
	always_comb begin
		acc      = psel & penable;
		wr       = acc & pwrite;
		rd_setup = psel & ~penable & ~pwrite;
		mapped   = (paddr[1:0] == 2'b00) && (paddr <= dse_pkg::OFF_CAPB_LO);
		pready   = 1'b1;
		pslverr  = acc & ~mapped;
	end

	// instruction fields and operand forming
	always_comb begin
		opc    = cmd_q[dse_pkg::CMD_OP_LSB +: 4];
		ra_num = cmd_q[dse_pkg::CMD_RA_LSB +: 8];
		rb_num = cmd_q[dse_pkg::CMD_RB_LSB +: 8];
		rc_num = ref_q[dse_pkg::REF_RC_LSB +: 8];
		vnum   = ref_q[dse_pkg::REF_VN_LSB +: 8];
		src_b  = cmd_q[dse_pkg::CMD_M_BIT] ? {24'h00_0000, cmd_q[dse_pkg::CMD_IMM_LSB +: 8]} : second_source_operand_q;
		dbl_a  = {first_source_operand_q, first_source_operand_tw_q};
		dbl_b  = {second_source_operand_q, second_source_operand_tw_q};
	end

	// one shared adder; remainder fix-up always adds
	always_comb begin
		alu.a   = first_source_operand_q;
		alu.b   = src_b;
		alu.sub = (opc == dse_pkg::OP_REM_FIX) ? 1'b0 : df_q;
		new_df  = ~(alu.carry ^ df_q ^ n_q);
		rem_val = df_q ? first_source_operand_q : alu.sum;
	end

	// ****************************************
	// next state: registers, execution, traps
	// ****************************************
	// execution runs in the cycle after the command write, so a
	// software write and a result write never land on one edge
	always_comb begin
		state_d   = state_q;
		cmd_d     = cmd_q;
		ref_d     = ref_q;
		first_source_operand_d    = first_source_operand_q;
		first_source_operand_tw_d = first_source_operand_tw_q;
		second_source_operand_d    = second_source_operand_q;
		second_source_operand_tw_d = second_source_operand_tw_q;
		q_d       = q_q;
		dest_d    = dest_q;
		df_d      = df_q;
		n_d       = n_q;
		v_d       = v_q;
		z_d       = z_q;
		c_d       = c_q;
		frm_d     = frm_q;
		ipa_d     = ipa_q;
		ipb_d     = ipb_q;
		ipc_d     = ipc_q;
		trap_d    = trap_q;
		prot_d    = prot_q;
		tvec_d    = tvec_q;
		pulse_d   = 1'b0;
		cap_a_d   = cap_a_q;
		cap_b_d   = cap_b_q;
		if (wr && mapped) begin
			case (paddr)
				dse_pkg::OFF_CMD: begin
					cmd_d   = pwdata;
					trap_d  = 1'b0;
					prot_d  = 1'b0;
					state_d = DSE_EXEC;
				end
				dse_pkg::OFF_REF:     ref_d     = pwdata;
				dse_pkg::OFF_FIRST_SOURCE_OPERAND:    first_source_operand_d    = pwdata;
				dse_pkg::OFF_FIRST_SOURCE_OPERAND_TW: first_source_operand_tw_d = pwdata;
				dse_pkg::OFF_SECOND_SOURCE_OPERAND:    second_source_operand_d    = pwdata;
				dse_pkg::OFF_SECOND_SOURCE_OPERAND_TW: second_source_operand_tw_d = pwdata;
				dse_pkg::OFF_QREG:    q_d       = pwdata;
				dse_pkg::OFF_STAT: begin
					df_d  = pwdata[dse_pkg::ST_DF];
					n_d   = pwdata[dse_pkg::ST_N];
					v_d   = pwdata[dse_pkg::ST_V];
					z_d   = pwdata[dse_pkg::ST_Z];
					c_d   = pwdata[dse_pkg::ST_C];
					frm_d = pwdata[dse_pkg::ST_FRM_LSB +: FRM_W];
				end
				default: begin
				end
			endcase
		end
		case (state_q)
			DSE_IDLE: begin
			end
			DSE_EXEC: begin
				state_d = DSE_IDLE;
				case (opc)
					dse_pkg::OP_QUOT_INIT: begin
						df_d   = 1'b1;
						n_d    = src_b[31];
						dest_d = {src_b[30:0], q_q[31]};
						q_d    = {q_q[30:0], 1'b0};
						z_d    = (src_b == dse_pkg::RST_WORD);
						v_d    = 1'b0;
						c_d    = 1'b0;
					end
					dse_pkg::OP_QUOT_STEP: begin
						df_d   = new_df;
						n_d    = alu.sum[31];
						dest_d = {alu.sum[30:0], q_q[31]};
						q_d    = {q_q[30:0], new_df};
						z_d    = (alu.sum == dse_pkg::RST_WORD);
						v_d    = alu.ovf;
						c_d    = alu.carry;
					end
					dse_pkg::OP_QUOT_LAST: begin
						df_d   = new_df;
						n_d    = alu.sum[31];
						dest_d = alu.sum;
						q_d    = {q_q[30:0], new_df};
						z_d    = (alu.sum == dse_pkg::RST_WORD);
						v_d    = alu.ovf;
						c_d    = alu.carry;
					end
					dse_pkg::OP_REM_FIX: begin
						dest_d = rem_val;
						n_d    = rem_val[31];
						z_d    = (rem_val == dse_pkg::RST_WORD);
						v_d    = df_q ? 1'b0 : alu.ovf;
						c_d    = df_q ? 1'b0 : alu.carry;
					end
					// trapping ops touch only refs, captures and trap state
					dse_pkg::OP_DBL_GE, dse_pkg::OP_DBL_GT,
					dse_pkg::OP_DBL_MUL, dse_pkg::OP_DBL_SUB,
					dse_pkg::OP_SLONG_Q, dse_pkg::OP_ULONG_Q: begin
						ipa_d   = ra_num;
						ipb_d   = rb_num;
						ipc_d   = rc_num;
						cap_a_d = dbl_a;
						cap_b_d = dbl_b;
						trap_d  = 1'b1;
						pulse_d = 1'b1;
						case (opc)
							// no compare path reads frm_q, so rounding mode cannot matter
							dse_pkg::OP_DBL_GE:  tvec_d = VEC_DBL_GE;
							dse_pkg::OP_DBL_GT:  tvec_d = VEC_DBL_GT;
							dse_pkg::OP_SLONG_Q: tvec_d = VEC_SLONG_Q;
							dse_pkg::OP_ULONG_Q: tvec_d = VEC_ULONG_Q;
							dse_pkg::OP_DBL_MUL: tvec_d = VEC_DBL_MUL;
							default:             tvec_d = VEC_DBL_SUB;
						endcase
					end
					dse_pkg::OP_SW_TRAP: begin
						trap_d  = 1'b1;
						pulse_d = 1'b1;
						if (cmd_q[dse_pkg::CMD_USR_BIT] && (vnum <= dse_pkg::USER_VEC_MAX)) begin
							prot_d = 1'b1;
							tvec_d = VEC_PROT;
						end else begin
							ipa_d  = ra_num;
							ipb_d  = rb_num;
							ipc_d  = rc_num;
							tvec_d = vnum;
						end
					end
					default: begin
					end
				endcase
			end
			default: state_d = DSE_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= DSE_IDLE;
			cmd_q     <= dse_pkg::RST_WORD;
			ref_q     <= dse_pkg::RST_WORD;
			first_source_operand_q    <= dse_pkg::RST_WORD;
			first_source_operand_tw_q <= dse_pkg::RST_WORD;
			second_source_operand_q    <= dse_pkg::RST_WORD;
			second_source_operand_tw_q <= dse_pkg::RST_WORD;
			q_q       <= dse_pkg::RST_WORD;
			dest_q    <= dse_pkg::RST_WORD;
			df_q      <= 1'b0;
			n_q       <= 1'b0;
			v_q       <= 1'b0;
			z_q       <= 1'b0;
			c_q       <= 1'b0;
			frm_q     <= '0;
			ipa_q     <= 8'h00;
			ipb_q     <= 8'h00;
			ipc_q     <= 8'h00;
			trap_q    <= 1'b0;
			prot_q    <= 1'b0;
			tvec_q    <= 8'h00;
			pulse_q   <= 1'b0;
			cap_a_q   <= 64'h0000_0000_0000_0000;
			cap_b_q   <= 64'h0000_0000_0000_0000;
		end else begin
			state_q   <= state_d;
			cmd_q     <= cmd_d;
			ref_q     <= ref_d;
			first_source_operand_q    <= first_source_operand_d;
			first_source_operand_tw_q <= first_source_operand_tw_d;
			second_source_operand_q    <= second_source_operand_d;
			second_source_operand_tw_q <= second_source_operand_tw_d;
			q_q       <= q_d;
			dest_q    <= dest_d;
			df_q      <= df_d;
			n_q       <= n_d;
			v_q       <= v_d;
			z_q       <= z_d;
			c_q       <= c_d;
			frm_q     <= frm_d;
			ipa_q     <= ipa_d;
			ipb_q     <= ipb_d;
			ipc_q     <= ipc_d;
			trap_q    <= trap_d;
			prot_q    <= prot_d;
			tvec_q    <= tvec_d;
			pulse_q   <= pulse_d;
			cap_a_q   <= cap_a_d;
			cap_b_q   <= cap_b_d;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// sampled in the setup cycle so read data leave a flip-flop
	always_comb begin
		prdata_d = prdata_q;
		if (rd_setup) begin
			case (paddr)
				dse_pkg::OFF_CMD:     prdata_d = cmd_q;
				dse_pkg::OFF_REF:     prdata_d = ref_q;
				dse_pkg::OFF_FIRST_SOURCE_OPERAND:    prdata_d = first_source_operand_q;
				dse_pkg::OFF_FIRST_SOURCE_OPERAND_TW: prdata_d = first_source_operand_tw_q;
				dse_pkg::OFF_SECOND_SOURCE_OPERAND:    prdata_d = second_source_operand_q;
				dse_pkg::OFF_SECOND_SOURCE_OPERAND_TW: prdata_d = second_source_operand_tw_q;
				dse_pkg::OFF_QREG:    prdata_d = q_q;
				dse_pkg::OFF_STAT: begin
					prdata_d = dse_pkg::RST_WORD;
					prdata_d[dse_pkg::ST_DF] = df_q;
					prdata_d[dse_pkg::ST_N]  = n_q;
					prdata_d[dse_pkg::ST_V]  = v_q;
					prdata_d[dse_pkg::ST_Z]  = z_q;
					prdata_d[dse_pkg::ST_C]  = c_q;
					prdata_d[dse_pkg::ST_FRM_LSB +: FRM_W] = frm_q;
				end
				dse_pkg::OFF_DEST:    prdata_d = dest_q;
				dse_pkg::OFF_OPREF:   prdata_d = {8'h00, ipc_q, ipb_q, ipa_q};
				dse_pkg::OFF_TRAP: begin
					prdata_d = dse_pkg::RST_WORD;
					prdata_d[dse_pkg::TR_VALID] = trap_q;
					prdata_d[dse_pkg::TR_PROT]  = prot_q;
					prdata_d[dse_pkg::TR_VEC_LSB +: 8] = tvec_q;
				end
				dse_pkg::OFF_CAPA_HI: prdata_d = cap_a_q[63:32];
				dse_pkg::OFF_CAPA_LO: prdata_d = cap_a_q[31:0];
				dse_pkg::OFF_CAPB_HI: prdata_d = cap_b_q[63:32];
				dse_pkg::OFF_CAPB_LO: prdata_d = cap_b_q[31:0];
				default:              prdata_d = dse_pkg::RST_WORD;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= dse_pkg::RST_WORD;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// trap outputs straight from flops
	always_comb begin
		prdata      = prdata_q;
		trap_pulse  = pulse_q;
		trap_vector = tvec_q;
	end

endmodule

/* dse_core_assertions.sv */
`timescale 1ns/1ps
module dse_core_assertions #(
	parameter logic [7:0] VEC_DBL_GE  = 8'h01,
	parameter logic [7:0] VEC_DBL_GT  = 8'h02,
	parameter logic [7:0] VEC_SLONG_Q = 8'h03,
	parameter logic [7:0] VEC_ULONG_Q = 8'h04,
	parameter logic [7:0] VEC_DBL_MUL = 8'h05,
	parameter logic [7:0] VEC_DBL_SUB = 8'h06,
	parameter logic [7:0] VEC_PROT    = 8'h07
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        trap_pulse,
	input wire logic [7:0]  trap_vector
);
	// ******
	// decode
	// ******
	logic       cwr;
	logic       swt;
	logic [3:0] op;
	logic [7:0] vn_d;
	logic [7:0] vn_q;
	// command write seen at the access edge
	assign cwr = psel && penable && pwrite && paddr == dse_pkg::OFF_CMD;
	assign op  = pwdata[3:0];
	assign swt = cwr && op == dse_pkg::OP_SW_TRAP;
	// shadow of the vector field; the trap vector is predicted from it
	always_comb begin
		vn_d = vn_q;
		if (psel && penable && pwrite && paddr == dse_pkg::OFF_REF) begin
			vn_d = pwdata[15:8];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vn_q <= 8'h00;
		end else begin
			vn_q <= vn_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// **********
	// properties
	// **********
	a_ge_trap: assert property (cwr && op == dse_pkg::OP_DBL_GE |-> ##[1:2] trap_pulse && trap_vector == VEC_DBL_GE)
		else $error("ge compare did not trap");
	a_gt_trap: assert property (cwr && op == dse_pkg::OP_DBL_GT |-> ##[1:2] trap_pulse && trap_vector == VEC_DBL_GT)
		else $error("gt compare did not trap");
	a_sq_trap: assert property (cwr && op == dse_pkg::OP_SLONG_Q |-> ##[1:2] trap_pulse && trap_vector == VEC_SLONG_Q)
		else $error("signed quotient did not trap");
	a_uq_trap: assert property (cwr && op == dse_pkg::OP_ULONG_Q |-> ##[1:2] trap_pulse && trap_vector == VEC_ULONG_Q)
		else $error("unsigned quotient did not trap");
	a_mul_trap: assert property (cwr && op == dse_pkg::OP_DBL_MUL |-> ##[1:2] trap_pulse && trap_vector == VEC_DBL_MUL)
		else $error("multiply did not trap");
	a_sub_trap: assert property (cwr && op == dse_pkg::OP_DBL_SUB |-> ##[1:2] trap_pulse && trap_vector == VEC_DBL_SUB)
		else $error("subtract did not trap");
	a_sw_vector: assert property (swt && !(pwdata[5] && vn_q <= dse_pkg::USER_VEC_MAX) |-> ##[1:2] trap_pulse && trap_vector == vn_q)
		else $error("software trap vector wrong");
	a_user_prot: assert property (swt && pwdata[5] && vn_q <= dse_pkg::USER_VEC_MAX |-> ##[1:2] trap_pulse && trap_vector == VEC_PROT)
		else $error("protection trap missing");
	a_div_no_trap: assert property (cwr && op <= dse_pkg::OP_REM_FIX |=> !trap_pulse [*2])
		else $error("divide primitive trapped");
	a_pulse_cause: assert property ($rose(trap_pulse) |-> ($past(cwr, 1) || $past(cwr, 2)) ##1 !trap_pulse)
		else $error("trap pulse without command or too long");
endmodule
bind dse_core dse_core_assertions #(.VEC_DBL_GE(VEC_DBL_GE), .VEC_DBL_GT(VEC_DBL_GT), .VEC_SLONG_Q(VEC_SLONG_Q),
	.VEC_ULONG_Q(VEC_ULONG_Q), .VEC_DBL_MUL(VEC_DBL_MUL), .VEC_DBL_SUB(VEC_DBL_SUB), .VEC_PROT(VEC_PROT)) chk_u (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trap_pulse(trap_pulse),
	.trap_vector(trap_vector));

/* divide_step_and_trap_emulation_tb_top.sv */
`timescale 1ns/1ps
module divide_step_and_trap_emulation_tb_top;
	// vectors differ from the defaults so a missed parameter shows up
	localparam logic [7:0] VEC [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
	localparam logic [3:0] TOPS [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
	localparam logic [7:0] SVN [3] = '{8'h05, 8'h3F, 8'h40};
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        trap_pulse;
	logic [7:0]  trap_vector;
	int          err_total;
	int          comparisons;
	int          cycles;
	int          pulses;
	int          p0;
	logic [31:0] rd;
	logic        er;
	logic [31:0] e_dest;
	logic [31:0] e_q;
	logic [31:0] e_st;
	logic [7:0]  k;
	dse_core #(.VEC_DBL_GE(VEC[0]), .VEC_DBL_GT(VEC[1]), .VEC_SLONG_Q(VEC[2]), .VEC_ULONG_Q(VEC[3]),
		.VEC_DBL_MUL(VEC[4]), .VEC_DBL_SUB(VEC[5]), .VEC_PROT(8'h17)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trap_pulse(trap_pulse),
		.trap_vector(trap_vector));
	// ********
	// services
	// ********
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one apb transfer plus an idle cycle, so no signal is driven twice at one edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask
	// reference model of one divide primitive, then run it and compare
	task automatic dcase(input logic [3:0] op, input logic [31:0] a, b, q, input logic [1:0] fl, input logic m,
		input logic [7:0] imm);
		logic [31:0] bb;
		logic [31:0] r;
		logic        c;
		logic        nd;
		bb = m ? {24'h00_0000, imm} : b;
		{c, r} = fl[0] ? {1'b0, a} + {1'b0, ~bb} + 33'h1 : {1'b0, a} + {1'b0, bb};
		nd = ~(c ^ fl[0] ^ fl[1]);
		e_q = {q[30:0], nd};
		e_dest = op == dse_pkg::OP_QUOT_STEP ? {r[30:0], q[31]} : r;
		e_st = {30'h0, r[31], nd};
		if (op == dse_pkg::OP_QUOT_INIT) begin
			e_dest = {bb[30:0], q[31]};
			e_q = {q[30:0], 1'b0};
			e_st = {30'h0, bb[31], 1'b1};
		end else if (op == dse_pkg::OP_REM_FIX) begin
			e_dest = fl[0] ? a : a + bb;
			e_q = q;
			e_st = {30'h0, e_dest[31], fl[0]};
		end
		wr(dse_pkg::OFF_FIRST_SOURCE_OPERAND, a);
		wr(dse_pkg::OFF_SECOND_SOURCE_OPERAND, b);
		wr(dse_pkg::OFF_QREG, q);
		wr(dse_pkg::OFF_STAT, {30'h0, fl});
		wr(dse_pkg::OFF_CMD, {16'h0000, imm, 3'b000, m, op});
		rchk("dest", dse_pkg::OFF_DEST, e_dest);
		rchk("q", dse_pkg::OFF_QREG, e_q);
		xfer(dse_pkg::OFF_STAT, 1'b0, 32'h0000_0000);
		chk("flags", rd & 32'h0000_0003, e_st);
	endtask
	// *****
	// clock
	// *****
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// watchdog and trap pulse counter
	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge pclk) begin
		pulses <= pulses + (trap_pulse === 1'b1);
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			test_done();
		end
	end
	// ********
	// sequence
	// ********
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{err_total, comparisons, cycles, pulses} = '0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("dest rst", dse_pkg::OFF_DEST, 32'h0000_0000);
		rchk("trap rst", dse_pkg::OFF_TRAP, 32'h0000_0000);
		dcase(4'h0, 32'h0000_0001, 32'h8000_0003, 32'hC000_0001, 2'b00, 1'b0, 8'h00);
		dcase(4'h0, 32'h0000_0001, 32'h8765_4321, 32'h4000_0001, 2'b10, 1'b1, 8'hF0);
		dcase(4'h1, 32'h0000_0010, 32'h0000_0020, 32'h8000_0000, 2'b01, 1'b0, 8'h00);
		dcase(4'h1, 32'hFFFF_FFF0, 32'h0000_0020, 32'h0000_0001, 2'b10, 1'b0, 8'h00);
		dcase(4'h2, 32'h0000_0030, 32'h0000_0010, 32'h1234_5678, 2'b01, 1'b0, 8'h00);
		dcase(4'h2, 32'h7FFF_FFFF, 32'h0000_0000, 32'h8765_4321, 2'b00, 1'b1, 8'h81);
		dcase(4'h3, 32'h0000_0007, 32'h0000_0005, 32'h0000_0009, 2'b01, 1'b0, 8'h00);
		dcase(4'h3, 32'hFFFF_FFF9, 32'h0000_000C, 32'h0000_0009, 2'b00, 1'b0, 8'h00);
		// each trapping op; round mode varies with the loop index
		for (int i = 0; i < 6; i++) begin
			k = 8'(i);
			p0 = pulses;
			e_st = {22'h0, 2'(i), 3'b000, 5'h15};
			wr(dse_pkg::OFF_FIRST_SOURCE_OPERAND, {24'hA0_0000, k});
			wr(dse_pkg::OFF_FIRST_SOURCE_OPERAND_TW, {24'hA1_0000, k});
			wr(dse_pkg::OFF_SECOND_SOURCE_OPERAND, {24'hB0_0000, k});
			wr(dse_pkg::OFF_SECOND_SOURCE_OPERAND_TW, {24'hB1_0000, k});
			wr(dse_pkg::OFF_STAT, e_st);
			wr(dse_pkg::OFF_REF, {24'h00_0000, 8'h30 + k});
			wr(dse_pkg::OFF_CMD, {8'h20 + k, 8'h10 + k, 8'h00, 4'h0, TOPS[i]});
			rchk("trap", dse_pkg::OFF_TRAP, {16'h0000, VEC[i], 8'h01});
			rchk("opref", dse_pkg::OFF_OPREF, {8'h00, 8'h30 + k, 8'h20 + k, 8'h10 + k});
			rchk("a hi", dse_pkg::OFF_CAPA_HI, {24'hA0_0000, k});
			rchk("a lo", dse_pkg::OFF_CAPA_LO, {24'hA1_0000, k});
			rchk("b hi", dse_pkg::OFF_CAPB_HI, {24'hB0_0000, k});
			rchk("b lo", dse_pkg::OFF_CAPB_LO, {24'hB1_0000, k});
			rchk("dest kept", dse_pkg::OFF_DEST, e_dest);
			rchk("q kept", dse_pkg::OFF_QREG, e_q);
			rchk("stat kept", dse_pkg::OFF_STAT, e_st);
			chk("vector", {24'h00_0000, trap_vector}, VEC[i]);
			chk("pulses", pulses - p0, 32'h0000_0001);
		end
		// software trap: supervisor low vector, user at and above the boundary
		for (int i = 0; i < 3; i++) begin
			k = 8'(i);
			wr(dse_pkg::OFF_REF, {16'h0000, SVN[i], 8'h33});
			wr(dse_pkg::OFF_CMD, {8'h50 + k, 8'h40 + k, 8'h00, 2'b00, i > 0, 1'b0, 4'hA});
			rchk("sw trap", dse_pkg::OFF_TRAP, i == 1 ? 32'h0000_1703 : {16'h0000, SVN[i], 8'h01});
			xfer(dse_pkg::OFF_OPREF, 1'b0, 32'h0000_0000);
			chk("sw refs", rd & 32'h0000_FFFF, {16'h0000, 8'h50 + k * 8'(i != 1), 8'h40 + k * 8'(i != 1)});
		end
		// emulation side: a non-zero remainder keeps the dividend's sign
		chk("sw rem sign", 32'(-7 % 2), 32'hFFFF_FFFF);
		// refused and read-only accesses
		xfer(8'h3C, 1'b0, 32'h0000_0000);
		chk("unmapped err", {31'h0, er}, 32'h0000_0001);
		wr(dse_pkg::OFF_DEST, 32'hFFFF_FFFF);
		rchk("dest ro", dse_pkg::OFF_DEST, e_dest);
		test_done();
	end
endmodule
